// ---- pkg/ufc_map.svh ----
// Purpose: Register map, field positions and counts of the UART FIFO control block
// Assumes: Included by bare name wherever the constants are needed
// Notes:   Definitions only
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH

// ==================================================================
// Register addresses on the parallel port
`define UFC_A_DATA 3'h0
`define UFC_A_IER 3'h1
`define UFC_A_ISR 3'h2
`define UFC_A_LCR 3'h3
`define UFC_A_LSR 3'h5

// ==================================================================
// Field positions
`define UFC_FCR_EN 0
`define UFC_FCR_RXCLR 1
`define UFC_FCR_TXCLR 2
`define UFC_FCR_MODE 3
`define UFC_FCR_TRIG_LO 6
`define UFC_LCR_DLAB 7
`define UFC_IER_RDA 0
`define UFC_IER_THRE 1
`define UFC_IER_LS 2
`define UFC_IER_MS 3

// ==================================================================
// Reset values
`define UFC_IER_RST 8'h00
`define UFC_LCR_RST 8'h00
`define UFC_DIV_RST 16'h0000

// ==================================================================
// FIFO sizes and receive trigger levels
`define UFC_DEPTH_N 16
`define UFC_DEPTH 5'h10
`define UFC_DEPTH_NF 5'h01
`define UFC_TRIG_1 5'h01
`define UFC_TRIG_4 5'h04
`define UFC_TRIG_8 5'h08
`define UFC_TRIG_14 5'h0E

// ==================================================================
// Interrupt identification codes
`define UFC_ID_LS 4'h6
`define UFC_ID_RDA 4'h4
`define UFC_ID_TO 4'hC
`define UFC_ID_THRE 4'h2
`define UFC_ID_MS 4'h0
`define UFC_ID_NONE 4'h1

// ==================================================================
// Receive timeout in bit times, and the oversampling ratio
`define UFC_TO_MUL 10'h004
`define UFC_TO_ADD 10'h00C
`define UFC_WL_BASE 10'h005
`define UFC_OVS 10'h010

`endif

// ---- pkg/ufc_pkg.sv ----
// Purpose: Shared types of the UART FIFO control block
// Assumes: Nothing beyond the map header
// Notes:   Received characters travel with their error flags
package ufc_pkg;

    // ==================================================================
    // Received character with its reception flags
    typedef struct packed {
        logic brk;
        logic frm;
        logic par;
        logic [7:0] data;
    } ufc_rxchar_s;

    typedef logic [4:0] ufc_cnt_t;

endpackage

// ---- rtl/ufc_top.sv ----
// Purpose: FIFO, interrupt and baud control of one UART channel
// Assumes: Bus strobes and serial-side inputs are synchronous to clk_sys
// Notes:   Serial shifters, modem registers and scratchpad sit outside
`timescale 1ns/1ns
`include "ufc_map.svh"

// What this block does
// - Data-ready status stays set while any byte is in the receive FIFO
// - Status bits one to four report overrun, parity, framing, break
// - Status bit five is set when the transmit FIFO is empty
// - Status bit six needs transmit FIFO and shifter both empty
// - Baud counter divides the clock by a 16-bit two-byte divisor
// - Baud output runs at sixteen times the bit rate
// - Enable bits 0..3 gate data, transmit, line and modem interrupts
// - Upper four enable bits always read zero
// - Status read shows only the highest pending interrupt
// - Codes: line 0110, data 0100, timeout 1100, transmit 0010, modem 0000
// - Status bit zero is low while an enabled interrupt pends
// - Bits 5:4 read zero, bits 7:6 follow FIFO enable
// - Timeout only in FIFO mode and never with an empty FIFO
// - Timeout restarts at stop centre, expires after 4*length+12 bits
// - Control bit zero enables both FIFOs; host sets it first
// - Control bit one empties the receive FIFO and self-clears
// - Control bit two empties the transmit FIFO and self-clears
// - Control bit three picks ready-pin mode one
// - Mode zero: transmit-ready low while nothing is queued
// - Mode zero: receive-ready low while a character waits
// - Mode one: transmit-ready high only when the FIFO is full
// - Mode one: receive-ready low at trigger or timeout until empty
// - Trigger levels 1, 4, 8, 14 from control bits seven and six
// - Divisor bytes appear at shared addresses only with latch bit set
// - Status bit seven flags an errored character in FIFO mode, clears on read
module ufc_top
    import ufc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire ufc_rxchar_s rx_char,
    input wire logic rx_char_valid,
    input wire logic rx_stop_mid,
    input wire logic modem_int,
    input wire logic tx_shift_empty,
    output logic [7:0] tx_char,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic baud16,
    output logic irq,
    output logic receive_ready_pin_n,
    output logic transmit_ready_pin_n
);

    // ==================================================================
    // Declarations
    logic rd_prev_q, wr_prev_q, rd_act, wr_act, rd_stb, wr_stb;
    logic rd_rhr, rd_isr, rd_lsr;
    logic wr_thr, wr_ier, wr_fcr, wr_lcr, wr_dll, wr_dlm;
    logic [7:0] ier_q, lcr_q, rdata, data_out_q;
    logic data_oe_q;
    logic fifo_en_q, mode1_q;
    logic [1:0] trig_sel_q;
    logic [15:0] div_q, b_cnt_q;
    logic baud16_q, dlab, fifo_mode1;
    ufc_cnt_t limit, trig, rx_cnt_q, tx_cnt_q;
    ufc_rxchar_s rx_mem [0:`UFC_DEPTH_N-1];
    logic [7:0] tx_mem [0:`UFC_DEPTH_N-1];
    logic [3:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
    logic rx_push, rx_pop, rx_ovr, rx_clr, tx_push, tx_pop, tx_clr;
    ufc_rxchar_s rx_head;
    logic [3:0] err_ev, lsr_err;
    logic lsr7_q, rx_bad;
    logic [9:0] to_cnt_q, to_lim, wl;
    logic to_flag_q, to_set;
    logic thre_q, tx_empty, tx_empty_prev_q, tx_all_empty;
    logic [7:0] sk_q, out_q;
    logic sk_v_q, out_v_q;
    logic ls_p, rda_p, to_p, thre_p, ms_p, any_p;
    logic [3:0] isr_id;
    logic irq_q, rxr_n_q, txr_n_q;

    // Receive trigger level from the two-bit code
    function automatic ufc_cnt_t trig_of(input logic [1:0] code);
        case (code)
            2'h0: trig_of = `UFC_TRIG_1;
            2'h1: trig_of = `UFC_TRIG_4;
            2'h2: trig_of = `UFC_TRIG_8;
            default: trig_of = `UFC_TRIG_14;
        endcase
    endfunction

    // ==================================================================
    // Bus strobes: act once on the leading edge of each access
    assign rd_act = ~cs_n & ~rd_n;
    assign wr_act = ~cs_n & ~wr_n;
    assign rd_stb = rd_act & ~rd_prev_q;
    assign wr_stb = wr_act & ~wr_prev_q;
    assign dlab = lcr_q[`UFC_LCR_DLAB];

    // Previous strobe levels for edge detection
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
        end else begin
            rd_prev_q <= rd_act;
            wr_prev_q <= wr_act;
        end
    end

    // Read side-effect decode
    always_comb begin
        rd_rhr = 1'b0;
        rd_isr = 1'b0;
        rd_lsr = 1'b0;
        if (rd_stb && addr == `UFC_A_DATA && !dlab) begin
            rd_rhr = 1'b1;
        end else if (rd_stb && addr == `UFC_A_ISR) begin
            rd_isr = 1'b1;
        end else if (rd_stb && addr == `UFC_A_LSR) begin
            rd_lsr = 1'b1;
        end
    end

    // Write decode; divisor bytes shadow data and enable registers
    always_comb begin
        wr_thr = 1'b0;
        wr_ier = 1'b0;
        wr_fcr = 1'b0;
        wr_lcr = 1'b0;
        wr_dll = 1'b0;
        wr_dlm = 1'b0;
        if (wr_stb && addr == `UFC_A_DATA) begin
            wr_dll = dlab;
            wr_thr = !dlab;
        end else if (wr_stb && addr == `UFC_A_IER) begin
            wr_dlm = dlab;
            wr_ier = !dlab;
        end else if (wr_stb && addr == `UFC_A_ISR) begin
            wr_fcr = 1'b1;
        end else if (wr_stb && addr == `UFC_A_LCR) begin
            wr_lcr = 1'b1;
        end
    end

    // ==================================================================
    // Control registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ier_q <= `UFC_IER_RST;
            lcr_q <= `UFC_LCR_RST;
        end else begin
            if (wr_ier) ier_q <= {4'h0, data_in[3:0]};
            if (wr_lcr) lcr_q <= data_in;
        end
    end

    // FIFO control; clear bits are pulses and never stored
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fifo_en_q <= 1'b0;
            mode1_q <= 1'b0;
            trig_sel_q <= 2'h0;
        end else if (wr_fcr) begin
            fifo_en_q <= data_in[`UFC_FCR_EN];
            mode1_q <= data_in[`UFC_FCR_MODE];
            trig_sel_q <= data_in[`UFC_FCR_TRIG_LO +: 2];
        end
    end

    assign rx_clr = wr_fcr & data_in[`UFC_FCR_RXCLR];
    assign tx_clr = wr_fcr & data_in[`UFC_FCR_TXCLR];
    assign limit = fifo_en_q ? `UFC_DEPTH : `UFC_DEPTH_NF;
    assign trig = trig_of(trig_sel_q);
    assign fifo_mode1 = fifo_en_q & mode1_q;

    // ==================================================================
    // Baud generator: one pulse every divisor clocks, zero halts it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= `UFC_DIV_RST;
        end else begin
            if (wr_dll) div_q[7:0] <= data_in;
            if (wr_dlm) div_q[15:8] <= data_in;
        end
    end

    // Divider counter, restarted on each divisor write
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            b_cnt_q <= 16'h0000;
            baud16_q <= 1'b0;
        end else if (wr_dll || wr_dlm || div_q == 16'h0000) begin
            b_cnt_q <= 16'h0000;
            baud16_q <= 1'b0;
        end else if (b_cnt_q >= div_q - 16'h0001) begin
            b_cnt_q <= 16'h0000;
            baud16_q <= 1'b1;
        end else begin
            b_cnt_q <= b_cnt_q + 16'h0001;
            baud16_q <= 1'b0;
        end
    end

    // ==================================================================
    // Receive FIFO; a character arriving when full is an overrun
    assign rx_push = rx_char_valid && rx_cnt_q < limit;
    assign rx_ovr = rx_char_valid && !(rx_cnt_q < limit);
    assign rx_pop = rd_rhr && rx_cnt_q != 5'h00;
    assign rx_head = rx_mem[rx_rp_q];

    // Storage for received characters
    always_ff @(posedge clk_sys) begin
        if (rx_push) rx_mem[rx_wp_q] <= rx_char;
    end

    // Pointers and fill count
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_wp_q <= 4'h0;
            rx_rp_q <= 4'h0;
            rx_cnt_q <= 5'h00;
        end else if (rx_clr) begin
            rx_wp_q <= 4'h0;
            rx_rp_q <= 4'h0;
            rx_cnt_q <= 5'h00;
        end else begin
            if (rx_push) rx_wp_q <= rx_wp_q + 4'h1;
            if (rx_pop) rx_rp_q <= rx_rp_q + 4'h1;
            rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
        end
    end

    // ==================================================================
    // Transmit FIFO feeding the two-entry output buffer
    assign tx_push = wr_thr && tx_cnt_q < limit;
    assign tx_pop = tx_cnt_q != 5'h00 && !sk_v_q;
    assign tx_empty = tx_cnt_q == 5'h00;

    // Storage for characters to send
    always_ff @(posedge clk_sys) begin
        if (tx_push) tx_mem[tx_wp_q] <= data_in;
    end

    // Pointers and fill count; the output stages are left alone
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_wp_q <= 4'h0;
            tx_rp_q <= 4'h0;
            tx_cnt_q <= 5'h00;
        end else if (tx_clr) begin
            tx_wp_q <= 4'h0;
            tx_rp_q <= 4'h0;
            tx_cnt_q <= 5'h00;
        end else begin
            if (tx_push) tx_wp_q <= tx_wp_q + 4'h1;
            if (tx_pop) tx_rp_q <= tx_rp_q + 4'h1;
            tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
        end
    end

    // Skid pair: a stalled shifter parks the next word in the spare slot
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            out_q <= 8'h00;
            out_v_q <= 1'b0;
            sk_q <= 8'h00;
            sk_v_q <= 1'b0;
        end else if (!out_v_q || tx_ready) begin
            if (sk_v_q) begin
                out_q <= sk_q;
                out_v_q <= 1'b1;
                sk_v_q <= 1'b0;
            end else begin
                out_q <= tx_mem[tx_rp_q];
                out_v_q <= tx_pop;
            end
        end else if (tx_pop) begin
            sk_q <= tx_mem[tx_rp_q];
            sk_v_q <= 1'b1;
        end
    end

    assign tx_all_empty = tx_empty & !sk_v_q & !out_v_q & tx_shift_empty;

    // ==================================================================
    // Line status error flags, sticky until the status is read
    assign err_ev = {rx_push & rx_char.brk, rx_push & rx_char.frm,
                     rx_push & rx_char.par, rx_ovr};
    assign rx_bad = rx_char.brk | rx_char.frm | rx_char.par;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_err
            logic bit_q;
            // A new error wins over the clearing read
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    bit_q <= 1'b0;
                end else if (err_ev[gi]) begin
                    bit_q <= 1'b1;
                end else if (rd_lsr) begin
                    bit_q <= 1'b0;
                end
            end
            assign lsr_err[gi] = bit_q;
        end
    endgenerate

    // Errored character in the FIFO, FIFO mode only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lsr7_q <= 1'b0;
        end else if (rx_push && rx_bad && fifo_en_q) begin
            lsr7_q <= 1'b1;
        end else if (rd_lsr || !fifo_en_q) begin
            lsr7_q <= 1'b0;
        end
    end

    // ==================================================================
    // Receive timeout counted in 16x ticks
    assign wl = `UFC_WL_BASE + {8'h00, lcr_q[1:0]};
    assign to_lim = (wl * `UFC_TO_MUL + `UFC_TO_ADD) * `UFC_OVS;
    assign to_set = baud16_q && to_cnt_q == to_lim - 10'h001
                    && fifo_en_q && rx_cnt_q != 5'h00;

    // Counter restarts at each stop centre, read, or empty FIFO
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            to_cnt_q <= 10'h000;
        end else if (rx_stop_mid || rx_pop || rx_clr || rx_cnt_q == 5'h00) begin
            to_cnt_q <= 10'h000;
        end else if (baud16_q && to_cnt_q < to_lim) begin
            to_cnt_q <= to_cnt_q + 10'h001;
        end
    end

    // Timeout flag; expiry wins over a read in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            to_flag_q <= 1'b0;
        end else if (to_set) begin
            to_flag_q <= 1'b1;
        end else if (rx_pop || rx_clr || rx_stop_mid || !fifo_en_q) begin
            to_flag_q <= 1'b0;
        end
    end

    // ==================================================================
    // Transmit-empty interrupt, set when the FIFO drains
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_empty_prev_q <= 1'b1;
            thre_q <= 1'b0;
        end else begin
            tx_empty_prev_q <= tx_empty;
            if (tx_empty && !tx_empty_prev_q) begin
                thre_q <= 1'b1;
            end else if (wr_thr || (rd_isr && isr_id == `UFC_ID_THRE)) begin
                thre_q <= 1'b0;
            end
        end
    end

    // Pending sources, each gated by its enable
    assign ls_p = ier_q[`UFC_IER_LS] & (|lsr_err);
    assign rda_p = ier_q[`UFC_IER_RDA]
                   & (fifo_en_q ? rx_cnt_q >= trig : rx_cnt_q != 5'h00);
    assign to_p = ier_q[`UFC_IER_RDA] & to_flag_q & fifo_en_q
                  & rx_cnt_q != 5'h00;
    assign thre_p = ier_q[`UFC_IER_THRE] & thre_q;
    assign ms_p = ier_q[`UFC_IER_MS] & modem_int;
    assign any_p = ls_p | rda_p | to_p | thre_p | ms_p;

    // Priority encoder: only the highest pending source is shown
    always_comb begin
        if (ls_p) begin
            isr_id = `UFC_ID_LS;
        end else if (rda_p) begin
            isr_id = `UFC_ID_RDA;
        end else if (to_p) begin
            isr_id = `UFC_ID_TO;
        end else if (thre_p) begin
            isr_id = `UFC_ID_THRE;
        end else if (ms_p) begin
            isr_id = `UFC_ID_MS;
        end else begin
            isr_id = `UFC_ID_NONE;
        end
    end

    // ==================================================================
    // Read data mux
    always_comb begin
        if (addr == `UFC_A_DATA) begin
            rdata = dlab ? div_q[7:0] : rx_head.data;
        end else if (addr == `UFC_A_IER) begin
            rdata = dlab ? div_q[15:8] : ier_q;
        end else if (addr == `UFC_A_ISR) begin
            rdata = {fifo_en_q, fifo_en_q, 2'h0, isr_id};
        end else if (addr == `UFC_A_LCR) begin
            rdata = lcr_q;
        end else if (addr == `UFC_A_LSR) begin
            rdata = {lsr7_q, tx_all_empty, tx_empty, lsr_err,
                     rx_cnt_q != 5'h00};
        end else begin
            rdata = 8'h00;
        end
    end

    // Registered read data, driven while the read strobe is held
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_out_q <= 8'h00;
            data_oe_q <= 1'b0;
        end else begin
            if (rd_stb) data_out_q <= rdata;
            data_oe_q <= rd_act;
        end
    end

    // ==================================================================
    // Interrupt and ready pins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
            txr_n_q <= 1'b1;
            rxr_n_q <= 1'b1;
        end else begin
            irq_q <= any_p;
            if (fifo_mode1) begin
                txr_n_q <= tx_cnt_q == `UFC_DEPTH;
                if (rx_cnt_q >= trig || to_flag_q) begin
                    rxr_n_q <= 1'b0;
                end else if (rx_cnt_q == 5'h00) begin
                    rxr_n_q <= 1'b1;
                end
            end else begin
                txr_n_q <= !tx_empty;
                rxr_n_q <= rx_cnt_q == 5'h00;
            end
        end
    end

    assign data_out = data_out_q;
    assign data_oe = data_oe_q;
    assign tx_char = out_q;
    assign tx_valid = out_v_q;
    assign baud16 = baud16_q;
    assign irq = irq_q;
    assign receive_ready_pin_n = rxr_n_q;
    assign transmit_ready_pin_n = txr_n_q;

    // ==================================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_rx_flush;
        wr_fcr && data_in[`UFC_FCR_RXCLR];
    endsequence

    sequence s_tx_flush;
        wr_fcr && data_in[`UFC_FCR_TXCLR];
    endsequence

    a_lsr_data_ready: assert property (
        rd_lsr |=> data_out_q[0] == ($past(rx_cnt_q) != 5'h00))
        else $error("data ready bit disagrees with receive fill");
    a_lsr_tx_empty: assert property (
        rd_lsr && !tx_empty |=> !data_out_q[6] && !data_out_q[5])
        else $error("transmit empty bits set with data queued");
    a_ier_upper_zero: assert property (
        rd_stb && addr == `UFC_A_IER && !dlab |=> data_out_q[7:4] == 4'h0)
        else $error("upper enable bits not zero");
    a_isr_idle_bit: assert property (
        rd_isr |=> data_out_q[0] == !$past(any_p))
        else $error("interrupt status bit zero wrong");
    a_isr_top_bits: assert property (
        rd_isr |=> data_out_q[7:4] == {{2{$past(fifo_en_q)}}, 2'h0})
        else $error("interrupt status upper bits wrong");
    a_isr_line_first: assert property (
        rd_isr && ls_p |=> data_out_q[3:0] == `UFC_ID_LS)
        else $error("line status not reported first");
    a_timeout_gate: assert property (
        $rose(to_flag_q) |-> $past(fifo_en_q) && $past(rx_cnt_q) != 5'h00)
        else $error("timeout raised outside FIFO mode or when empty");
    a_rx_flush_done: assert property (
        s_rx_flush |=> rx_cnt_q == 5'h00 ##1 !mode1_q || rx_cnt_q <= 5'h01)
        else $error("receive FIFO not emptied");
    a_tx_flush_done: assert property (
        s_tx_flush |=> tx_cnt_q == 5'h00)
        else $error("transmit FIFO not emptied");
    a_transmit_ready_pin_mode1: assert property (
        $past(fifo_mode1) |-> txr_n_q == ($past(tx_cnt_q) == `UFC_DEPTH))
        else $error("transmit ready pin wrong in mode one");
    a_int_masked: assert property (
        ier_q[3:0] == 4'h0 |=> !irq_q)
        else $error("interrupt raised while all sources masked");
    a_baud_pulse: assert property (
        baud16_q && div_q >= 16'h0002 && !wr_dll && !wr_dlm |=> !baud16_q)
        else $error("baud pulse longer than one clock");

endmodule

// ---- tb/ufc_tx_sink.sv ----
// Purpose: Transmit shifter stand-in that takes characters
// Assumes: One clock, accept on tx_valid and tx_ready high
// Notes:   Ready stalls on a fixed pattern
`timescale 1ns/1ns
// ==================================================================
// Sink
module ufc_tx_sink (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] tx_char,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] last_q,
    output logic [7:0] count_q
);
    logic [2:0] pat_q;
    // Stall pattern and capture of accepted words
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pat_q <= 3'h0;
            tx_ready <= 1'b0;
            last_q <= 8'h00;
            count_q <= 8'h00;
        end else begin
            pat_q <= pat_q + 3'h1;
            tx_ready <= pat_q[2];
            if (tx_valid && tx_ready) begin
                last_q <= tx_char;
                count_q <= count_q + 8'h01;
            end
        end
    end
endmodule

// ---- tb/ufc_top_bench.sv ----
// Purpose: Self-checking bench of the FIFO control block
// Assumes: Inputs change at the falling edge
// Notes:   Serial side stubs tie stop pulse, modem and shifter state
`timescale 1ns/1ns
`include "ufc_map.svh"
module ufc_top_bench;
    import ufc_pkg::*;
    logic clk_sys = 0, reset_n = 0, cs_n = 1, rd_n = 1, wr_n = 1, rx_char_valid = 0;
    logic [2:0] addr = 3'h0;
    logic [7:0] data_in = 8'h00, data_out, tx_char, last, cnt, v, d1, d2;
    ufc_rxchar_s rx_char = '0;
    logic data_oe, tx_valid, tx_ready, baud16, irq, rrdy_n, trdy_n;
    int mismatches = 0, checked = 0, pulses;
    logic [31:0] seed = 32'h52E4;
    always #2 clk_sys = ~clk_sys;
    ufc_top i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .rx_char(rx_char), .rx_char_valid(rx_char_valid), .rx_stop_mid(1'b0),
        .modem_int(1'b0), .tx_shift_empty(1'b1), .tx_char(tx_char), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .baud16(baud16), .irq(irq), .receive_ready_pin_n(rrdy_n),
        .transmit_ready_pin_n(trdy_n));
    ufc_tx_sink i_sink (.clk_sys(clk_sys), .reset_n(reset_n), .tx_char(tx_char),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .last_q(last), .count_q(cnt));
    // ==================================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_sys) {cs_n, wr_n, addr, data_in} = {2'b00, a, d};
        @(negedge clk_sys) {cs_n, wr_n} = 2'b11;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk_sys) {cs_n, rd_n, addr} = {2'b00, a};
        @(negedge clk_sys);
        @(negedge clk_sys) d = data_out;
        {cs_n, rd_n} = 2'b11;
        @(negedge clk_sys);
    endtask
    task automatic push(input logic p, input logic [7:0] d);
        @(negedge clk_sys) rx_char = '{brk: 1'b0, frm: 1'b0, par: p, data: d};
        rx_char_valid = 1;
        @(negedge clk_sys) rx_char_valid = 0;
    endtask
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100000 mismatches++;
        tally_and_finish();
    end
    // ==================================================================
    // Tests
    initial begin
        repeat (2) @(negedge clk_sys);
        reset_n = 1;
        rd(`UFC_A_IER, v); chk("ier", 8'h00, v);
        rd(`UFC_A_ISR, v); chk("isr", 8'h01, v);
        rd(3'h4, v); chk("unmapped", 8'h00, v);
        seed = xs(seed);
        wr(`UFC_A_IER, seed[7:0] | 8'hF0);
        rd(`UFC_A_IER, v); chk("ier", seed[7:0] & 8'h0F, v);
        $display("test registers done");
        wr(`UFC_A_IER, 8'h05);
        wr(`UFC_A_ISR, 8'h01);
        seed = xs(seed); d1 = seed[7:0]; d2 = seed[15:8];
        push(1'b0, d1);
        rd(`UFC_A_ISR, v); chk("isr", 8'hC4, v);
        chk("rrdy", 8'h00, {7'h0, rrdy_n});
        push(1'b1, d2);
        rd(`UFC_A_ISR, v); chk("isr", 8'hC6, v);
        rd(`UFC_A_LSR, v); chk("lsr", 8'hE5, v);
        rd(`UFC_A_ISR, v); chk("isr", 8'hC4, v);
        rd(`UFC_A_DATA, v); chk("rx", d1, v);
        rd(`UFC_A_LSR, v); chk("lsr", 8'h61, v);
        rd(`UFC_A_DATA, v); chk("rx", d2, v);
        rd(`UFC_A_LSR, v); chk("lsr", 8'h60, v);
        chk("rrdy", 8'h01, {7'h0, rrdy_n});
        push(1'b0, d1);
        wr(`UFC_A_ISR, 8'h03);
        rd(`UFC_A_LSR, v); chk("lsr", 8'h60, v);
        $display("test receive done");
        chk("trdy", 8'h00, {7'h0, trdy_n});
        wr(`UFC_A_DATA, d1);
        wr(`UFC_A_DATA, d2);
        for (int i = 0; i < 100 && cnt !== 8'h02; i++) @(negedge clk_sys);
        repeat (4) @(negedge clk_sys);
        chk("tx", d2, last);
        rd(`UFC_A_LSR, v); chk("lsr", 8'h60, v);
        $display("test transmit done");
        wr(`UFC_A_LCR, 8'h80);
        wr(`UFC_A_DATA, 8'h03);
        wr(`UFC_A_IER, 8'h00);
        wr(`UFC_A_LCR, 8'h03);
        pulses = 0;
        repeat (30) @(negedge clk_sys) pulses += baud16;
        chk("baud", 8'd10, pulses[7:0]);
        $display("test baud done");
        wr(`UFC_A_ISR, 8'hC9);
        push(1'b0, d2);
        rd(`UFC_A_ISR, v); chk("isr", 8'hC1, v);
        chk("irq", 8'h00, {7'h0, irq});
        chk("rrdy", 8'h01, {7'h0, rrdy_n});
        chk("trdy", 8'h00, {7'h0, trdy_n});
        repeat (2300) @(negedge clk_sys);
        chk("irq", 8'h01, {7'h0, irq});
        chk("rrdy", 8'h00, {7'h0, rrdy_n});
        rd(`UFC_A_ISR, v); chk("isr", 8'hCC, v);
        rd(`UFC_A_DATA, v); chk("rx", d2, v);
        chk("rrdy", 8'h01, {7'h0, rrdy_n});
        $display("test mode one done");
        tally_and_finish();
    end
endmodule
